/* rtl/cise_consts.vh */
// Constants for the instruction subset executor: opcode fields, widths and reset values.
// Assumes 14-bit instruction words and an 8-bit data path.
`ifndef CISE_CONSTS_VH
`define CISE_CONSTS_VH

// ****************************************************************
// Widths
// ****************************************************************
`define CISE_INSTR_W        14
`define CISE_DATA_W         8
`define CISE_PC_W           15
`define CISE_FADDR_W        7
`define CISE_FILE_DEPTH     128
`define CISE_LATCH_W        7

// ****************************************************************
// Instruction fields
// ****************************************************************
`define CISE_DEST_BIT       7
`define CISE_BRANCH_MSB     10
`define CISE_LATCH_HI       6
`define CISE_LATCH_LO       3

// ****************************************************************
// Opcode patterns
// ****************************************************************
`define CISE_OP6_DEC_FILE   6'h03
`define CISE_OP6_DEC_SKIP   6'h0B
`define CISE_OP6_INC_SKIP   6'h0F
`define CISE_OP7_CLEAR_ACC  7'h02
`define CISE_OP3_BRANCH     3'h5
`define CISE_OP6_OR_LIT     6'h38

// ****************************************************************
// ALU operation select
// ****************************************************************
`define CISE_ALU_DEC        2'h0
`define CISE_ALU_INC        2'h1
`define CISE_ALU_OR         2'h2
`define CISE_ALU_CLEAR      2'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define CISE_ACC_RST        8'h00
`define CISE_ZERO_RST       1'b0
`define CISE_PC_RST         15'h0000
`define CISE_FILE_RST       8'h00

`endif

/* rtl/cise_alu.v */
// Combinational 8-bit arithmetic for the instruction subset executor.
// Assumes the caller picks the destination and decides whether the zero flag is kept.
`timescale 1ns/10ps
`include "cise_consts.vh"

module cise_alu (
	input  wire [1:0]              op_sel,
	input  wire [`CISE_DATA_W-1:0] file_val,
	input  wire [`CISE_DATA_W-1:0] acc_val,
	input  wire [`CISE_DATA_W-1:0] literal,
	output reg  [`CISE_DATA_W-1:0] result,
	output wire                    result_zero
);

	always @* begin
		case (op_sel)
			`CISE_ALU_DEC: result = file_val - 8'h01; // (RULE11)
			`CISE_ALU_INC: result = file_val + 8'h01; // (RULE11)
			`CISE_ALU_OR: result = acc_val | literal;
			`CISE_ALU_CLEAR: result = 8'h00;
			default: result = 8'h00;
		endcase
	end

	assign result_zero = (result == 8'h00); // (RULE10)

endmodule

/* rtl/cise_core.v */
// Instruction subset executor: decodes one instruction word per cycle and updates
// the accumulator, the file registers, the zero flag and the program counter.
// Assumes program memory presents the word at pc_out with instr_valid, synchronous to ref_clk.
// Assumes rst is asynchronous and active high and clears the file storage as well.
`timescale 1ns/10ps
`include "cise_consts.vh"

// Overview of operation
// (RULE1) Decrement file register 0..127; destination bit picks accumulator or register; zero updated.
// (RULE2) Accumulator clear loads zero and sets the zero flag; no operands.
// (RULE3) Decrement-and-skip writes file minus one to chosen destination; flags untouched.
// (RULE4) Decrement-and-skip result zero discards next instruction as a no-operation.
// (RULE5) Increment-and-skip writes file plus one to chosen destination; flags untouched.
// (RULE6) Increment-and-skip result zero replaces next instruction with a no-operation.
// (RULE7) Branch loads 11-bit immediate into pc 10:0, upper latch bits 6:3 into pc 14:11.
// (RULE8) Branch takes two cycles and changes no status flag.
// (RULE9) Literal OR ors an 8-bit literal into the accumulator and updates zero.
// (RULE10) Zero flag set when the 8-bit result is zero, cleared otherwise.
// (RULE11) Increment and decrement wrap modulo 256.
module cise_core (
	input  wire                      ref_clk,
	input  wire                      rst,
	input  wire                      instr_valid,
	input  wire [`CISE_INSTR_W-1:0]  instr_word,
	input  wire [`CISE_LATCH_W-1:0]  pc_upper_latch,
	input  wire [`CISE_FADDR_W-1:0]  peek_addr,
	output reg  [`CISE_PC_W-1:0]     pc_out,
	output reg  [`CISE_DATA_W-1:0]   acc_out,
	output reg                       zero_out,
	output reg                       discard_out,
	output reg  [`CISE_DATA_W-1:0]   peek_data
);

	// ****************************************************************
	// State
	// ****************************************************************
	reg  [`CISE_DATA_W-1:0]  file_reg [0:`CISE_FILE_DEPTH-1];
	reg  [`CISE_DATA_W-1:0]  acc_reg;
	reg                      zero_reg;
	reg  [`CISE_PC_W-1:0]    pc_reg;
	reg                      discard_reg;
	reg  [`CISE_DATA_W-1:0]  acc_next;
	reg                      zero_next;
	reg  [`CISE_PC_W-1:0]    pc_next;
	reg                      discard_next;
	reg                      file_we;
	reg  [1:0]               alu_op;

	wire [`CISE_FADDR_W-1:0] faddr;
	wire                     dest_file;
	wire [`CISE_DATA_W-1:0]  file_val;
	wire [`CISE_DATA_W-1:0]  alu_result;
	wire                     alu_zero;
	wire                     execute;
	wire                     is_dec_file;
	wire                     is_dec_skip;
	wire                     is_inc_skip;
	wire                     is_clear_acc;
	wire                     is_branch;
	wire                     is_or_lit;
	wire                     is_skip;
	wire [5:0]               op6;
	wire [6:0]               op7;
	wire [2:0]               op3;
	wire [`CISE_PC_W-1:0]    branch_target;
	wire [`CISE_DATA_W-1:0]  peek_val;

	// ****************************************************************
	// Decode
	// ****************************************************************
	assign faddr        = instr_word[`CISE_FADDR_W-1:0];
	assign dest_file    = instr_word[`CISE_DEST_BIT];
	assign file_val     = file_reg[faddr];
	// A slot that follows a skip with a zero result, or a branch, is consumed but does nothing
	assign execute      = instr_valid & ~discard_reg;
	// Opcode fields of different lengths share the top of the word
	assign op6          = instr_word[13:8];
	assign op7          = instr_word[13:7];
	assign op3          = instr_word[13:11];
	assign is_dec_file  = (op6 == `CISE_OP6_DEC_FILE);
	assign is_dec_skip  = (op6 == `CISE_OP6_DEC_SKIP);
	assign is_inc_skip  = (op6 == `CISE_OP6_INC_SKIP);
	assign is_clear_acc = (op7 == `CISE_OP7_CLEAR_ACC);
	assign is_branch    = (op3 == `CISE_OP3_BRANCH);
	assign is_or_lit    = (op6 == `CISE_OP6_OR_LIT);
	assign is_skip      = is_dec_skip | is_inc_skip;
	assign branch_target = {pc_upper_latch[`CISE_LATCH_HI:`CISE_LATCH_LO],
		instr_word[`CISE_BRANCH_MSB:0]}; // (RULE7)
	assign peek_val     = file_reg[peek_addr];

	always @* begin
		if (is_inc_skip) begin
			alu_op = `CISE_ALU_INC;
		end else if (is_or_lit) begin
			alu_op = `CISE_ALU_OR;
		end else if (is_clear_acc) begin
			alu_op = `CISE_ALU_CLEAR;
		end else begin
			// Both decrement forms, and words that are not decoded
			alu_op = `CISE_ALU_DEC;
		end
	end

	// ****************************************************************
	// Arithmetic
	// ****************************************************************
	cise_alu cise_alu_i (
		.op_sel      (alu_op),
		.file_val    (file_val),
		.acc_val     (acc_reg),
		.literal     (instr_word[`CISE_DATA_W-1:0]),
		.result      (alu_result),
		.result_zero (alu_zero)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always @* begin
		acc_next     = acc_reg;
		zero_next    = zero_reg;
		pc_next      = pc_reg + 15'h0001;
		discard_next = discard_reg;
		file_we      = 1'b0;
		if (instr_valid) begin
			discard_next = 1'b0;
		end
		if (execute) begin
			if (is_dec_file) begin
				zero_next = alu_zero; // (RULE1)
				if (dest_file) begin
					file_we = 1'b1; // (RULE1)
				end else begin
					acc_next = alu_result; // (RULE1)
				end
			end else if (is_skip) begin
				// Flags deliberately left alone here
				if (dest_file) begin
					file_we = 1'b1; // (RULE3) (RULE5)
				end else begin
					acc_next = alu_result; // (RULE3) (RULE5)
				end
				discard_next = alu_zero; // (RULE4) (RULE6)
			end else if (is_clear_acc) begin
				acc_next  = 8'h00; // (RULE2)
				zero_next = 1'b1; // (RULE2)
			end else if (is_branch) begin
				pc_next = branch_target; // (RULE7)
				// The word presented next, at the branch target, is dropped as the second cycle
				discard_next = 1'b1; // (RULE8)
			end else if (is_or_lit) begin
				acc_next  = alu_result; // (RULE9)
				zero_next = alu_zero; // (RULE9)
			end
		end
		if (!instr_valid) begin
			pc_next = pc_reg;
		end
	end

	// ****************************************************************
	// State registers
	// ****************************************************************
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_reg     <= `CISE_ACC_RST;
			zero_reg    <= `CISE_ZERO_RST;
			pc_reg      <= `CISE_PC_RST;
			discard_reg <= 1'b0;
		end else begin
			acc_reg     <= acc_next;
			zero_reg    <= zero_next;
			pc_reg      <= pc_next;
			discard_reg <= discard_next;
		end
	end

	// ****************************************************************
	// Output registers
	// ****************************************************************
	// Outputs load the same next values as the state, so every pin is a flip-flop
	// at the cost of one duplicate register per bit
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pc_out      <= `CISE_PC_RST;
			acc_out     <= `CISE_ACC_RST;
			zero_out    <= `CISE_ZERO_RST;
			discard_out <= 1'b0;
		end else begin
			pc_out      <= pc_next;
			acc_out     <= acc_next;
			zero_out    <= zero_next;
			discard_out <= discard_next;
		end
	end

	// Peek has one cycle of latency and shows the storage before this edge's write
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			peek_data <= `CISE_FILE_RST;
		end else begin
			peek_data <= peek_val;
		end
	end

	// ****************************************************************
	// File storage
	// ****************************************************************
	// One write port per entry keeps each storage byte a plain flip-flop
	genvar gi;
	generate
		for (gi = 0; gi < `CISE_FILE_DEPTH; gi = gi + 1) begin : g_file
			wire entry_hit;
			// Address widened to the loop index width so the match compares equal widths
			assign entry_hit = file_we & ({25'h000_0000, faddr} == gi);
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					file_reg[gi] <= `CISE_FILE_RST;
				end else if (entry_hit) begin
					file_reg[gi] <= alu_result;
				end
			end
		end
	endgenerate

endmodule

/* bench/cise_prog_mem.sv */
// Program memory model: a 64-word store read at the low address bits.
// Assumes the bench fills mem before reset is released.
`timescale 1ns/10ps
module cise_prog_mem (
	input  wire [14:0] addr,
	output wire [13:0] word
);
	reg [13:0] mem [0:63];
	// Combinational read, so a branch target is presented in the very next slot
	assign word = mem[addr[5:0]];
endmodule

/* bench/cise_core_sva.sv */
// Checker for the instruction subset executor.
// Assumes it is bound to cise_core and sees only its ports.
`timescale 1ns/10ps
`include "cise_consts.vh"
module cise_core_sva (
	input wire        ref_clk,
	input wire        rst,
	input wire        instr_valid,
	input wire [13:0] instr_word,
	input wire [6:0]  pc_upper_latch,
	input wire [14:0] pc_out,
	input wire [7:0]  acc_out,
	input wire        zero_out,
	input wire        discard_out
);
	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire        ex  = instr_valid && !discard_out;
	wire [5:0]  op  = instr_word[13:8];
	wire        br  = ex && instr_word[13:11] == `CISE_OP3_BRANCH;
	wire        sk  = ex && (op == `CISE_OP6_DEC_SKIP || op == `CISE_OP6_INC_SKIP);
	wire [7:0]  lit = instr_word[7:0];
	wire [14:0] tgt = {pc_upper_latch[6:3], instr_word[10:0]};
	a_idle_hold: assert property (!instr_valid |=> $stable({pc_out, acc_out, zero_out, discard_out})) else $error("idle change");
	a_clear_acc: assert property (ex && instr_word[13:7] == `CISE_OP7_CLEAR_ACC |=> acc_out == 8'h00 && zero_out)
		else $error("clear wrong");
	a_branch_target: assert property (br |=> pc_out == $past(tgt) && discard_out) else $error("branch target");
	a_branch_flags: assert property (br |=> $stable(zero_out) && $stable(acc_out)) else $error("branch flags");
	a_or_literal: assert property (ex && op == `CISE_OP6_OR_LIT |=>
		acc_out == ($past(acc_out) | $past(lit)) && zero_out == (acc_out == 8'h00)) else $error("or wrong");
	a_skip_flags: assert property (sk |=> $stable(zero_out)) else $error("skip flag");
	a_skip_acc: assert property (sk && !instr_word[7] |=> discard_out == (acc_out == 8'h00)) else $error("skip");
	a_discard_nop: assert property (instr_valid && discard_out |=>
		!discard_out && $stable(acc_out) && pc_out == $past(pc_out) + 15'h0001) else $error("discard slot");
	a_dec_zero: assert property (ex && op == `CISE_OP6_DEC_FILE && !instr_word[7] |=>
		zero_out == (acc_out == 8'h00)) else $error("dec zero");
	c_branch: cover property (br);
	c_dec_skip: cover property (ex && op == `CISE_OP6_DEC_SKIP ##1 discard_out);
	c_inc_skip: cover property (ex && op == `CISE_OP6_INC_SKIP ##1 discard_out);
endmodule
bind cise_core cise_core_sva cise_core_sva_i (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
	.instr_word(instr_word), .pc_upper_latch(pc_upper_latch), .pc_out(pc_out), .acc_out(acc_out),
	.zero_out(zero_out), .discard_out(discard_out));

/* bench/tb_cise_core.sv */
// Self-checking bench: random program in the memory model, reference model in step.
// Assumes the design consumes one word per valid cycle and updates outputs at that edge.
`timescale 1ns/10ps
`include "cise_consts.vh"
module tb_cise_core;
	reg         ref_clk = 0;
	reg         rst = 1;
	reg         instr_valid = 0;
	reg  [6:0]  pc_upper_latch = 0;
	reg  [6:0]  peek_addr = 0;
	wire [13:0] instr_word;
	wire [14:0] pc_out;
	wire [7:0]  acc_out;
	wire        zero_out;
	wire        discard_out;
	wire [7:0]  peek_data;
	integer     fails = 0;
	integer     tests_run = 0;
	integer     seed = 31;
	integer     i;
	reg  [31:0] r;
	reg  [14:0] m_pc = 0;
	reg  [7:0]  m_acc = 0;
	reg  [7:0]  m_r;
	reg  [7:0]  pk;
	reg         m_z = 0;
	reg         m_d = 0;
	reg  [7:0]  m_f [0:127];
	reg  [13:0] w;
	reg  [32:0] q [$];
	always #5 ref_clk = ~ref_clk;
	cise_core cise_core_i (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word),
		.pc_upper_latch(pc_upper_latch), .peek_addr(peek_addr), .pc_out(pc_out), .acc_out(acc_out),
		.zero_out(zero_out), .discard_out(discard_out), .peek_data(peek_data));
	cise_prog_mem cise_prog_mem_i (.addr(pc_out), .word(instr_word));
	// ****************************************************************
	// Reference model, compare and report
	// ****************************************************************
	task check(input [32:0] got, input [32:0] exp); begin
		tests_run = tests_run + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("unexpected at %0t: state %h, wanted %h", $time, got, exp);
		end
	end endtask
	task final_report; begin
		$display("tests_run=%0d fails=%0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end endtask
	task step; begin
		w = cise_prog_mem_i.mem[m_pc[5:0]];
		pk = m_f[peek_addr];
		m_pc = m_pc + 15'h0001;
		if (m_d) m_d = 0;
		else if (w[13:11] == `CISE_OP3_BRANCH) begin
			m_pc = {pc_upper_latch[6:3], w[10:0]};
			m_d = 1;
		end else if (w[13:7] == `CISE_OP7_CLEAR_ACC) begin
			m_acc = 0;
			m_z = 1;
		end else if (w[13:8] == `CISE_OP6_OR_LIT) begin
			m_acc = m_acc | w[7:0];
			m_z = m_acc == 0;
		end else if (w[13:8] == `CISE_OP6_DEC_FILE || w[13:8] == `CISE_OP6_DEC_SKIP || w[13:8] == `CISE_OP6_INC_SKIP) begin
			m_r = (w[13:8] == `CISE_OP6_INC_SKIP) ? m_f[w[6:0]] + 8'h01 : m_f[w[6:0]] - 8'h01;
			if (w[7]) m_f[w[6:0]] = m_r;
			else m_acc = m_r;
			if (w[13:8] == `CISE_OP6_DEC_FILE) m_z = m_r == 0;
			else m_d = m_r == 0;
		end
		q.push_back({m_pc, m_acc, m_z, m_d, pk});
	end endtask
	// Results land at the taken edge; look once they have settled
	always @(posedge ref_clk) if (!rst && instr_valid) begin
		#2;
		if (q.size() == 0) check(33'h0_0000_0000, 33'h1_FFFF_FFFF);
		else check({pc_out, acc_out, zero_out, discard_out, peek_data}, q.pop_front());
	end
	initial begin
		for (i = 0; i < 128; i = i + 1) m_f[i] = 0;
		// Few files in use, so wrap and zero results come up often
		for (i = 0; i < 64; i = i + 1) begin
			r = $random(seed);
			case (r[30:28])
				0: w = {`CISE_OP6_DEC_FILE, r[7], 5'h00, r[1:0]};
				1: w = {`CISE_OP6_DEC_SKIP, r[7], 5'h00, r[1:0]};
				2, 7: w = {`CISE_OP6_INC_SKIP, r[7], 5'h00, r[1:0]};
				3: w = {`CISE_OP7_CLEAR_ACC, r[6:0]};
				4: w = {`CISE_OP3_BRANCH, r[10:0]};
				5: w = {`CISE_OP6_OR_LIT, r[7:0]};
				default: w = r[13:0];
			endcase
			cise_prog_mem_i.mem[i] = w;
		end
		repeat (6) @(posedge ref_clk);
		#1 rst = 0;
		repeat (3000) begin
			r = $random(seed);
			instr_valid = r[0] | r[1];
			pc_upper_latch = r[14:8];
			peek_addr = {5'h00, r[3:2]};
			if (instr_valid) step;
			@(posedge ref_clk);
			#1;
		end
		instr_valid = 0;
		repeat (2) @(posedge ref_clk);
		if (q.size() != 0) check(33'h0_0000_0000, 33'h1_FFFF_FFFF);
		final_report;
	end
endmodule
